/* File: logic/fan_mode_gpio_alarm_ctrl.sv */
// Fan controller core: mode, drive, pin functions, count window and alarms
`timescale 1ns/1ps
// Summary of operation
// [R1] Prescaler bits 2:0 divide the overflow_alarm_a feedback by 1,2,4,8,16; reset is 4.
// [R2] Config bit 3 selects 5V (0) or 12V (1) fan class; reset 12V.
// [R3] Bits 5:4 pick full-on, off, closed-loop, open-loop; bits 7:6 read zero.
// [R4] Closed loop steps the drive level until overflow_alarm_a count meets the speed target.
// [R5] In open loop the host reads counts and writes the drive value itself.
// [R6] Full-on mode drives the maximum level.
// [R7] Pin 1 as full-on input, held low, forces maximum drive over all modes.
// [R8] Pins are open drain; sampled levels read back in pin status.
// [R9] After reset no pin is pulled low.
// [R10] Definition bits 7 and 6 pull pins 4 and 3 low when zero; reset one.
// [R11] Bits 5:4: pin 2 external clock, clock out, low, or released.
// [R12] Bits 3:2: pin 1 released, full-on input, or low.
// [R13] Bits 1:0: pin 0 released, alert output, or low.
// [R14] Pin 0 as alert pulls low while an enabled alarm is latched.
// [R15] Only enabled alarms set status or drive the alert.
// [R16] Max and min level alarms act only in closed-loop mode.
// [R17] Reading alarm status clears latched bits and releases the alert.
// [R18] A read clears a bit only if its cause is gone.
// [R19] Enable bits: pin2, pin1, overflow, min, max at 4..0; reset zero.
// [R20] Pin 1 and pin 2 alarms set while those pins are sensed low.
// [R21] Alert releases when no enabled status bit is set, reasserts on a latch.
module fan_mode_gpio_alarm_ctrl #(
  parameter int unsigned WIN_BASE_CYCLES = fan_pkg::BASE_WIN_CYCLES,
  parameter int unsigned CLKOUT_HALF = fan_pkg::CLKOUT_HALF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic overflow_alarm_a_in,
  input wire logic [4:0] pin_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic [7:0] fan_drive,
  output logic fan_voltage_select,
  output logic ext_clk_sel
);
  localparam int GW = fan_pkg::GRAY_W;

  typedef struct packed {
    logic [7:0] speed;
    logic [5:0] cfg;
    logic [7:0] pin_def;
    logic [7:0] dac;
    logic [4:0] alm_en;
    logic [4:0] alm_stat;
    logic [7:0] overflow_alarm_a_cnt;
    logic [1:0] count_time;
    logic [GW-1:0] g_meta;
    logic [GW-1:0] g_sync;
    logic [GW-1:0] win_start;
    logic [27:0] win_cnt;
    logic [7:0] loop_level;
    logic [7:0] drive;
    logic [4:0] pin_oe;
    logic [4:0] pin_out;
    logic vsel;
    logic ext_sel;
    logic [7:0] clk_div;
    logic clk_tog;
    logic [7:0] rdata;
  } core_state_t;

  core_state_t q, nxt;
  overflow_alarm_a_link_if overflow_alarm_a_bus ();
  logic [4:0] pin_s;

  // Combinational helpers, all driven by the single next-state process
  logic [GW-1:0] cnt_now;
  logic [GW-1:0] delta;
  logic [27:0] win_len;
  logic win_end;
  logic ovf;
  logic [7:0] sat;
  logic [7:0] feedback;
  logic closed;
  logic override;
  logic lvl_up;
  logic lvl_dn;
  logic max_hit;
  logic min_hit;
  logic [4:0] cond;
  logic [4:0] stat_base;
  logic alert_on;
  fan_pkg::fan_mode_t mode;

  overflow_alarm_a_counter u_overflow_alarm_a (
    .link_clk(link_clk),
    .nrst(nrst),
    .overflow_alarm_a_in(overflow_alarm_a_in),
    .overflow_alarm_a_bus(overflow_alarm_a_bus.src)
  );

  pin_sync #(.W(5)) u_pin_sync (
    .clk(ref_clk),
    .nrst(nrst),
    .d_in(pin_in),
    .q_out(pin_s)
  );

  // Next-state logic for the whole core
  always_comb begin
    nxt = q;
    mode = fan_pkg::fan_mode_t'(q.cfg[fan_pkg::CFG_MODE_LSB +: 2]);
    closed = (mode == fan_pkg::MODE_CLOSED);
    override = (q.pin_def[fan_pkg::PIN1_FN_LSB +: 2] == fan_pkg::PF_SPECIAL) && !pin_s[1];

    // Gray count crosses by two flops; only the second one is decoded
    nxt.g_meta = overflow_alarm_a_bus.gray_cnt;
    nxt.g_sync = q.g_meta;
    cnt_now = fan_pkg::gray_to_bin(q.g_sync);
    delta = cnt_now - q.win_start;

    // Count window of 0.25 s times two to the count-time code
    win_len = 28'(WIN_BASE_CYCLES) << q.count_time;
    // Greater-or-equal, so a shorter count time ends a long running window at once
    win_end = (q.win_cnt >= win_len - 28'd1);
    ovf = win_end && (delta > GW'(255));
    sat = ovf ? fan_pkg::OVERFLOW_ALARM_A_SAT : delta[7:0];
    feedback = sat >> fan_pkg::scale_shift(q.cfg[fan_pkg::CFG_SCALE_LSB +: 3]); // [R1]
    if (win_end) begin
      nxt.win_cnt = 28'd0;
      nxt.win_start = cnt_now;
      nxt.overflow_alarm_a_cnt = sat;
    end else begin
      nxt.win_cnt = q.win_cnt + 28'd1;
    end

    // One step per window keeps the loop slow against fan inertia
    lvl_up = win_end && closed && (feedback < q.speed); // [R4]
    lvl_dn = win_end && closed && (feedback > q.speed); // [R4]
    max_hit = lvl_up && (q.loop_level == fan_pkg::DRIVE_MAX); // [R16]
    min_hit = lvl_dn && (q.loop_level == fan_pkg::DRIVE_MIN); // [R16]
    if (lvl_up && !max_hit) begin
      nxt.loop_level = q.loop_level + 8'h01; // [R4]
    end else if (lvl_dn && !min_hit) begin
      nxt.loop_level = q.loop_level - 8'h01; // [R4]
    end

    // Alarm causes in status bit order
    cond = '0;
    cond[fan_pkg::ALM_MAX] = max_hit;
    cond[fan_pkg::ALM_MIN] = min_hit;
    cond[fan_pkg::ALM_OVF] = ovf;
    cond[fan_pkg::ALM_PIN1] = !pin_s[1]; // [R20]
    cond[fan_pkg::ALM_PIN2] = !pin_s[2]; // [R20]

    // A read clears only causes that are gone; a new cause wins over the clear
    stat_base = q.alm_stat;
    if (reg_rd && reg_addr == fan_pkg::ADDR_ALM_STAT) begin
      stat_base = q.alm_stat & cond; // [R17] [R18]
    end
    nxt.alm_stat = stat_base | (cond & q.alm_en); // [R15]

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        fan_pkg::ADDR_SPEED: nxt.speed = reg_wdata;
        fan_pkg::ADDR_CONFIG: nxt.cfg = reg_wdata[5:0]; // [R3]
        fan_pkg::ADDR_PIN_DEF: nxt.pin_def = reg_wdata;
        fan_pkg::ADDR_DAC: nxt.dac = reg_wdata; // [R5]
        fan_pkg::ADDR_ALM_EN: nxt.alm_en = reg_wdata[4:0]; // [R19]
        fan_pkg::ADDR_COUNT: nxt.count_time = reg_wdata[1:0];
        default: nxt.speed = q.speed;
      endcase
    end

    // Register reads, answered one cycle later; unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        fan_pkg::ADDR_SPEED: nxt.rdata = q.speed;
        fan_pkg::ADDR_CONFIG: nxt.rdata = {2'h0, q.cfg}; // [R3]
        fan_pkg::ADDR_PIN_DEF: nxt.rdata = q.pin_def;
        fan_pkg::ADDR_DAC: nxt.rdata = q.dac;
        fan_pkg::ADDR_ALM_EN: nxt.rdata = {3'h0, q.alm_en};
        fan_pkg::ADDR_ALM_STAT: nxt.rdata = {3'h0, q.alm_stat};
        fan_pkg::ADDR_OVERFLOW_ALARM_A: nxt.rdata = q.overflow_alarm_a_cnt;
        fan_pkg::ADDR_PIN_STAT: nxt.rdata = {3'h0, pin_s}; // [R8]
        fan_pkg::ADDR_COUNT: nxt.rdata = {6'h00, q.count_time};
        default: nxt.rdata = 8'h00;
      endcase
    end

    // Drive level per mode; the pin override beats every software setting
    if (override) begin
      nxt.drive = fan_pkg::DRIVE_MAX; // [R7]
    end else begin
      unique case (mode)
        fan_pkg::MODE_FULL_ON: nxt.drive = fan_pkg::DRIVE_MAX; // [R6]
        fan_pkg::MODE_OFF: nxt.drive = fan_pkg::DRIVE_MIN;
        fan_pkg::MODE_CLOSED: nxt.drive = q.loop_level; // [R4]
        fan_pkg::MODE_OPEN: nxt.drive = q.dac; // [R5]
      endcase
    end
    nxt.vsel = q.cfg[fan_pkg::CFG_VSEL_BIT]; // [R2]
    nxt.ext_sel = (q.pin_def[fan_pkg::PIN2_FN_LSB +: 2] == fan_pkg::P2_EXT_CLK); // [R11]

    // Internal clock copy for pin 2
    if (q.clk_div == 8'(CLKOUT_HALF - 1)) begin
      nxt.clk_div = 8'h00;
      nxt.clk_tog = !q.clk_tog;
    end else begin
      nxt.clk_div = q.clk_div + 8'h01;
    end

    // Open-drain pull-downs; alert follows the status just latched
    alert_on = |(nxt.alm_stat & q.alm_en); // [R14] [R21]
    nxt.pin_out = 5'h00;
    nxt.pin_oe[4] = !q.pin_def[fan_pkg::PIN4_BIT]; // [R10]
    nxt.pin_oe[3] = !q.pin_def[fan_pkg::PIN3_BIT]; // [R10]
    unique case (fan_pkg::pin2_fn_t'(q.pin_def[fan_pkg::PIN2_FN_LSB +: 2]))
      fan_pkg::P2_EXT_CLK: nxt.pin_oe[2] = 1'b0; // [R11]
      fan_pkg::P2_CLK_OUT: nxt.pin_oe[2] = !q.clk_tog; // [R11]
      fan_pkg::P2_LOW: nxt.pin_oe[2] = 1'b1; // [R11]
      fan_pkg::P2_RELEASE: nxt.pin_oe[2] = 1'b0; // [R11]
    endcase
    nxt.pin_oe[1] = (q.pin_def[fan_pkg::PIN1_FN_LSB +: 2] == fan_pkg::PF_LOW); // [R12]
    unique case (fan_pkg::pin_fn_t'(q.pin_def[fan_pkg::PIN0_FN_LSB +: 2]))
      fan_pkg::PF_SPECIAL: nxt.pin_oe[0] = alert_on; // [R13] [R14]
      fan_pkg::PF_LOW: nxt.pin_oe[0] = 1'b1; // [R13]
      default: nxt.pin_oe[0] = 1'b0; // [R13]
    endcase

    // Synchronous reset; every pull-down starts off
    if (!nrst) begin
      nxt = '0;
      nxt.speed = fan_pkg::RST_SPEED;
      nxt.cfg = fan_pkg::RST_CONFIG; // [R1] [R2] [R3]
      nxt.pin_def = fan_pkg::RST_PIN_DEF; // [R10]
      nxt.dac = fan_pkg::RST_DAC;
      nxt.alm_en = fan_pkg::RST_ALM_EN; // [R19]
      nxt.count_time = fan_pkg::RST_COUNT;
      nxt.loop_level = fan_pkg::DRIVE_MAX;
      nxt.drive = fan_pkg::DRIVE_MAX;
      nxt.vsel = 1'b1;
      nxt.pin_oe = 5'h00; // [R9]
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= nxt;
  end

  assign reg_rdata = q.rdata;
  assign pin_out = q.pin_out;
  assign pin_oe = q.pin_oe;
  assign fan_drive = q.drive;
  assign fan_voltage_select = q.vsel;
  assign ext_clk_sel = q.ext_sel;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_status_read;
    reg_rd && reg_addr == fan_pkg::ADDR_ALM_STAT;
  endsequence

  sequence s_pin1_low_enabled;
    !pin_s[1] && q.alm_en[fan_pkg::ALM_PIN1];
  endsequence

  a_cfg_reset: assert property ($rose(nrst) |-> q.cfg[2:0] == 3'h2) // [R1]
    else $error("prescaler not divide by 4 after reset");
  a_vsel_follow: assert property (fan_voltage_select == $past(q.cfg[3])) // [R2]
    else $error("voltage select does not follow config bit 3");
  a_cfg_write: assert property (reg_wr && reg_addr == fan_pkg::ADDR_CONFIG // [R3]
    |=> q.cfg == $past(reg_wdata[5:0]))
    else $error("config write not stored");
  a_cfg_top_zero: assert property (reg_rd && reg_addr == fan_pkg::ADDR_CONFIG // [R3]
    |=> reg_rdata[7:6] == 2'h0)
    else $error("config bits 7:6 not read as zero");
  a_loop_step_up: assert property (lvl_up && !max_hit // [R4]
    |=> q.loop_level == $past(q.loop_level) + 8'h01)
    else $error("closed loop did not raise level");
  a_full_on_drive: assert property (mode == fan_pkg::MODE_FULL_ON |=> fan_drive == 8'hff) // [R6]
    else $error("full-on mode not at maximum drive");
  a_override_wins: assert property (override[*2] |=> fan_drive == 8'hff) // [R7]
    else $error("pin override did not force maximum drive");
  a_pin_status_read: assert property (reg_rd && reg_addr == fan_pkg::ADDR_PIN_STAT // [R8]
    |=> reg_rdata == {3'h0, $past(pin_s)})
    else $error("pin status read mismatch");
  a_pins_released: assert property ($rose(nrst) |-> pin_oe == 5'h00) // [R9]
    else $error("pin pulled low after reset");
  a_pin4_low: assert property (!q.pin_def[7] |=> pin_oe[4]) // [R10]
    else $error("pin 4 not pulled low");
  a_pin2_low: assert property (q.pin_def[5:4] == 2'h2 |=> pin_oe[2] && !ext_clk_sel) // [R11]
    else $error("pin 2 low function wrong");
  a_pin1_low: assert property (q.pin_def[3:2] == 2'h2 |=> pin_oe[1]) // [R12]
    else $error("pin 1 not pulled low");
  a_pin0_low: assert property (q.pin_def[1:0] == 2'h2 |=> pin_oe[0]) // [R13]
    else $error("pin 0 not pulled low");
  a_alert_tracks: assert property ($past(q.pin_def[1:0]) == 2'h1 // [R14]
    |-> pin_oe[0] == |(q.alm_stat & $past(q.alm_en)))
    else $error("alert pin does not track enabled status");
  a_disabled_quiet: assert property (q.alm_en == 5'h00 && q.alm_stat == 5'h00 // [R15]
    |=> q.alm_stat == 5'h00)
    else $error("disabled alarm set status");
  a_level_alarm_mode: assert property (!closed && q.alm_stat[1:0] == 2'h0 // [R16]
    |=> q.alm_stat[1:0] == 2'h0)
    else $error("level alarm outside closed loop");
  a_read_clears: assert property (s_status_read and cond == 5'h00 // [R17]
    |=> q.alm_stat == 5'h00 ##1 pin_oe[0] == (q.pin_def[1:0] == 2'h2))
    else $error("status read did not clear alarms");
  a_read_keeps_cause: assert property (s_status_read and (q.alm_stat & cond) != 5'h00 // [R18]
    |=> (q.alm_stat & $past(q.alm_stat & cond)) == $past(q.alm_stat & cond))
    else $error("status read cleared a live alarm");
  a_enable_write: assert property (reg_wr && reg_addr == fan_pkg::ADDR_ALM_EN // [R19]
    |=> q.alm_en == $past(reg_wdata[4:0]))
    else $error("alarm enable write not stored");
  a_pin1_alarm: assert property (s_pin1_low_enabled |=> q.alm_stat[fan_pkg::ALM_PIN1]) // [R20]
    else $error("pin 1 alarm not latched");
  a_alert_release: assert property (q.pin_def[1:0] == 2'h1 && q.alm_stat == 5'h00 // [R21]
    && $past(q.pin_def[1:0]) == 2'h1 |-> !pin_oe[0])
    else $error("alert held with no alarm");

endmodule : fan_mode_gpio_alarm_ctrl

/* File: logic/fan_pkg.sv */
// Shared constants, field positions, modes and helpers of the fan controller
package fan_pkg;

  // Register command offsets
  localparam logic [7:0] ADDR_SPEED = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_PIN_DEF = 8'h04;
  localparam logic [7:0] ADDR_DAC = 8'h06;
  localparam logic [7:0] ADDR_ALM_EN = 8'h08;
  localparam logic [7:0] ADDR_ALM_STAT = 8'h0a;
  localparam logic [7:0] ADDR_OVERFLOW_ALARM_A = 8'h0c;
  localparam logic [7:0] ADDR_PIN_STAT = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h16;

  // Values after reset
  localparam logic [7:0] RST_SPEED = 8'h00;
  localparam logic [5:0] RST_CONFIG = 6'h0a;
  localparam logic [7:0] RST_PIN_DEF = 8'hff;
  localparam logic [7:0] RST_DAC = 8'h00;
  localparam logic [4:0] RST_ALM_EN = 5'h00;
  localparam logic [1:0] RST_COUNT = 2'h2;

  // Field positions
  localparam int CFG_SCALE_LSB = 0;
  localparam int CFG_VSEL_BIT = 3;
  localparam int CFG_MODE_LSB = 4;
  localparam int PIN0_FN_LSB = 0;
  localparam int PIN1_FN_LSB = 2;
  localparam int PIN2_FN_LSB = 4;
  localparam int PIN3_BIT = 6;
  localparam int PIN4_BIT = 7;
  localparam int ALM_MAX = 0;
  localparam int ALM_MIN = 1;
  localparam int ALM_OVF = 2;
  localparam int ALM_PIN1 = 3;
  localparam int ALM_PIN2 = 4;

  // Drive and count limits
  localparam logic [7:0] DRIVE_MAX = 8'hff;
  localparam logic [7:0] DRIVE_MIN = 8'h00;
  localparam logic [7:0] OVERFLOW_ALARM_A_SAT = 8'hff;
  localparam int GRAY_W = 12;

  // Count window timing
  localparam longint CLK_HZ = 40000000;
  localparam longint BASE_WIN_MS = 250;
  localparam int BASE_WIN_CYCLES = int'(BASE_WIN_MS * CLK_HZ / 1000);
  localparam int CLKOUT_HALF = 79;

  typedef enum logic [1:0] {
    MODE_FULL_ON = 2'b00,
    MODE_OFF = 2'b01,
    MODE_CLOSED = 2'b10,
    MODE_OPEN = 2'b11
  } fan_mode_t;

  typedef enum logic [1:0] {
    P2_EXT_CLK = 2'b00,
    P2_CLK_OUT = 2'b01,
    P2_LOW = 2'b10,
    P2_RELEASE = 2'b11
  } pin2_fn_t;

  typedef enum logic [1:0] {
    PF_RELEASE_A = 2'b00,
    PF_SPECIAL = 2'b01,
    PF_LOW = 2'b10,
    PF_RELEASE_B = 2'b11
  } pin_fn_t;

  // Prescaler code to shift; codes above 100 act as divide by 16
  function automatic logic [2:0] scale_shift(input logic [2:0] code);
    scale_shift = (code > 3'h4) ? 3'h4 : code;
  endfunction : scale_shift

  function automatic logic [GRAY_W-1:0] gray_to_bin(input logic [GRAY_W-1:0] g);
    logic [GRAY_W-1:0] b;
    b[GRAY_W-1] = g[GRAY_W-1];
    for (int i = GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray_to_bin = b;
  endfunction : gray_to_bin

endpackage : fan_pkg

/* File: logic/overflow_alarm_a_counter.sv */
// Link-domain tachometer edge counter with gray-coded output
`timescale 1ns/1ps
module overflow_alarm_a_counter (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic overflow_alarm_a_in,
  overflow_alarm_a_link_if.src overflow_alarm_a_bus
);
  localparam int GW = fan_pkg::GRAY_W;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic overflow_alarm_a_meta;
    logic overflow_alarm_a_sync;
    logic overflow_alarm_a_prev;
    logic [GW-1:0] bin;
    logic [GW-1:0] gray;
  } link_state_t;

  link_state_t q, nxt;
  logic [GW-1:0] bin_inc;

  // Reset and tachometer both cross into this clock before use
  always_comb begin
    nxt = q;
    bin_inc = q.bin + GW'(1);
    nxt.rst_meta = nrst;
    nxt.rst_sync = q.rst_meta;
    nxt.overflow_alarm_a_meta = overflow_alarm_a_in;
    nxt.overflow_alarm_a_sync = q.overflow_alarm_a_meta;
    nxt.overflow_alarm_a_prev = q.overflow_alarm_a_sync;
    if (q.overflow_alarm_a_sync && !q.overflow_alarm_a_prev) begin
      nxt.bin = bin_inc;
      nxt.gray = bin_inc ^ (bin_inc >> 1); // One bit moves per step [R4]
    end
    if (!q.rst_sync) begin
      nxt.overflow_alarm_a_prev = 1'b0;
      nxt.bin = '0;
      nxt.gray = '0;
    end
  end

  always_ff @(posedge link_clk) begin
    q <= nxt;
  end

  assign overflow_alarm_a_bus.gray_cnt = q.gray;

  // Core reset also gates it, since the local reset flops start unknown
  a_gray_single_step: assert property (@(posedge link_clk) disable iff (!nrst || !q.rst_sync) // [R4]
    $onehot0(q.gray ^ $past(q.gray)))
    else $error("gray count moved by more than one bit");

endmodule : overflow_alarm_a_counter

/* File: logic/overflow_alarm_a_link_if.sv */
// Gray-coded tachometer pulse count passed from the link domain to the core
`timescale 1ns/1ps
interface overflow_alarm_a_link_if;
  logic [fan_pkg::GRAY_W-1:0] gray_cnt;
  modport src (output gray_cnt);
  modport dst (input gray_cnt);
endinterface : overflow_alarm_a_link_if

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for the open-drain pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t q, nxt;

  // Pins idle high through their pull-ups
  always_comb begin
    nxt = q;
    nxt.meta = d_in;
    nxt.sync = q.meta;
    if (!nrst) begin
      nxt.meta = '1;
      nxt.sync = '1;
    end
  end

  always_ff @(posedge clk) begin
    q <= nxt;
  end

  assign q_out = q.sync;

endmodule : pin_sync

/* File: verification/fan_model.sv */
// Fan and board model: tachometer pulses and pulled-up open-drain pins
`timescale 1ns/1ps
module fan_model (
  input wire logic link_clk,
  input wire logic overflow_alarm_a_en,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] ext_low,
  output logic overflow_alarm_a_in,
  output logic [4:0] pin_in
);
  // One overflow_alarm_a rise per two link clocks, inside what the synchroniser can count
  initial overflow_alarm_a_in = 1'b0;
  always @(posedge link_clk) begin
    if (overflow_alarm_a_en) begin
      overflow_alarm_a_in <= ~overflow_alarm_a_in;
    end
  end
  // Pull-up wins unless the device or the board pulls the pad low
  assign pin_in = ~(pin_oe | ext_low);
endmodule : fan_model

/* File: verification/tb.sv */
// Self-checking bench for the fan mode, pin function and alarm core
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic overflow_alarm_a_en = 1'b0;
  logic [4:0] ext_low = 5'h00;
  logic overflow_alarm_a_in;
  logic [4:0] pin_in;
  logic [7:0] reg_rdata;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [7:0] fan_drive;
  logic fan_voltage_select;
  logic ext_clk_sel;
  logic [7:0] rd;
  logic po2;
  int err_count = 0;
  int checks_done = 0;
  int n;
  // Reset table, with an unmapped offset at the end that must read zero
  logic [7:0] ra [10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h14, 8'h16, 8'h0e};
  logic [7:0] rv [10] = '{8'h00, 8'h0a, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h02, 8'h00};
  logic [7:0] dv [4] = '{8'hff, 8'h00, 8'h00, 8'h40};
  logic [7:0] pd [4] = '{8'h00, 8'haa, 8'hb5, 8'h7f};
  logic [7:0] po [4] = '{8'h18, 8'h0f, 8'h08, 8'h10};

  // Core clock 25 ns, link clock 32 ns, no common phase
  always #12.5 ref_clk = ~ref_clk;
  always #16 link_clk = ~link_clk;

  // Short count window so closed loop and overflow fit in a short run
  fan_mode_gpio_alarm_ctrl #(
    .WIN_BASE_CYCLES(128),
    .CLKOUT_HALF(4)
  ) fan_mode_gpio_alarm_ctrl_i (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .link_clk(link_clk),
    .overflow_alarm_a_in(overflow_alarm_a_in),
    .pin_in(pin_in),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .fan_drive(fan_drive),
    .fan_voltage_select(fan_voltage_select),
    .ext_clk_sel(ext_clk_sel)
  );

  fan_model fan_model_i (
    .link_clk(link_clk),
    .overflow_alarm_a_en(overflow_alarm_a_en),
    .pin_oe(pin_oe),
    .ext_low(ext_low),
    .overflow_alarm_a_in(overflow_alarm_a_in),
    .pin_in(pin_in)
  );

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Wait k edges, then look at settled outputs mid-cycle
  task automatic look(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : look

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is registered on the taking edge and sampled half a cycle later
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd = reg_rdata;
  endtask : rdr

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the roughly 4400 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    test_done();
  end

  initial begin
    look(11);
    chk("drive_rst", fan_drive, 8'hff);
    chk("oe_rst", {3'h0, pin_oe}, 8'h00);
    chk("vsel_rst", {7'h0, fan_voltage_select}, 8'h01);
    @(posedge ref_clk);
    nrst <= 1'b1;
    overflow_alarm_a_en <= 1'b1;
    wr(8'h0a, 8'hff);
    for (int i = 0; i < 10; i++) begin
      rdr(ra[i]);
      chk("reg_rst", rd, rv[i]);
    end
    wr(8'h02, 8'hf4);
    rdr(8'h02);
    chk("cfg_top", rd, 8'h34);
    for (int s = 0; s < 5; s++) begin
      wr(8'h02, 8'h10 | 8'(s));
      rdr(8'h02);
      chk("cfg_scale", rd, 8'h10 | 8'(s));
      chk("vsel", {7'h0, fan_voltage_select}, 8'h00);
    end
    // Host picks the drive level itself for open loop
    wr(8'h06, 8'h40);
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        wr(8'h02, 8'h08 | 8'(m << 4));
        look(2);
        chk("drive_mode", fan_drive, dv[m]);
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, pd[i]);
      look(3);
      chk("pin_oe", {3'h0, pin_oe}, po[i]);
      chk("ext_clk", {7'h0, ext_clk_sel}, {7'h0, pd[i][5:4] == 2'b00});
      chk("pin_out", {3'h0, pin_out}, 8'h00);
      rdr(8'h14);
      chk("pin_stat", rd, 8'h1f & ~po[i]);
    end
    // Clock out toggles the pin 2 pull-down
    wr(8'h04, 8'hdf);
    look(1);
    po2 = pin_oe[2];
    n = 0;
    repeat (40) begin
      @(negedge ref_clk);
      if (pin_oe[2] !== po2) n++;
      po2 = pin_oe[2];
    end
    chk("clk_out", {7'h0, n > 3}, 8'h01);
    // Pin 1 low only overrides when set up as full-on input
    wr(8'h02, 8'h1a);
    wr(8'h04, 8'hfd);
    @(posedge ref_clk);
    ext_low <= 5'h02;
    look(6);
    chk("no_ovr", fan_drive, 8'h00);
    chk("alert_dis", {7'h0, pin_oe[0]}, 8'h00);
    rdr(8'h0a);
    chk("stat_dis", rd, 8'h00);
    wr(8'h04, 8'hf5);
    look(5);
    chk("ovr", fan_drive, 8'hff);
    @(posedge ref_clk);
    ext_low <= 5'h00;
    look(6);
    chk("ovr_off", fan_drive, 8'h00);
    wr(8'h04, 8'hfd);
    for (int i = 1; i < 3; i++) begin
      wr(8'h08, 8'h04 << i);
      @(posedge ref_clk);
      ext_low <= 5'(1 << i);
      look(5);
      chk("alert_on", {7'h0, pin_oe[0]}, 8'h01);
      rdr(8'h0a);
      chk("stat_held", rd, 8'h04 << i);
      @(posedge ref_clk);
      ext_low <= 5'h00;
      look(5);
      rdr(8'h0a);
      chk("stat_last", rd, 8'h04 << i);
      rdr(8'h0a);
      chk("stat_clr", rd, 8'h00);
      look(2);
      chk("alert_off", {7'h0, pin_oe[0]}, 8'h00);
    end
    wr(8'h08, 8'hff);
    rdr(8'h08);
    chk("alm_en", rd, 8'h1f);
    // Level alarms must stay quiet outside closed loop
    wr(8'h16, 8'h00);
    wr(8'h08, 8'h03);
    wr(8'h02, 8'h08);
    look(400);
    rdr(8'h0a);
    chk("lvl_alm_off", rd, 8'h00);
    wr(8'h00, 8'hff);
    wr(8'h02, 8'h20);
    look(400);
    rdr(8'h0a);
    chk("lvl_alm_on", rd, 8'h01);
    // Target between the divided and undivided counts, so the prescaler picks the way
    wr(8'h00, 8'h20);
    look(600);
    chk("loop_down", {7'h0, fan_drive < 8'hff}, 8'h01);
    rd = fan_drive;
    wr(8'h02, 8'h24);
    look(400);
    chk("loop_up", {7'h0, fan_drive > rd}, 8'h01);
    // Longest window holds about 400 overflow_alarm_a edges, past the 255 ceiling
    wr(8'h02, 8'h18);
    wr(8'h08, 8'h04);
    wr(8'h16, 8'h03);
    rdr(8'h0a);
    look(2300);
    rdr(8'h0c);
    chk("overflow_alarm_a_sat", rd, 8'hff);
    rdr(8'h0a);
    chk("ovf_alm", rd, 8'h04);
    test_done();
  end
endmodule : tb
